//--- ims_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ims_modem_model (
  // Clock and wanted line states, 1 = asserted
  input wire logic sys_clk,
  input wire logic [3:0] lineReq,
  input wire logic slow,
  // Modem control pins, active low
  output logic carrier_detect_pin_n,
  output logic ring_pin_n,
  output logic set_ready_pin_n,
  output logic clear_to_send_pin_n
);
  // ****************************************
  // Line drivers
  // ****************************************
  // A slow modem settles its lines three clocks late
  logic [3:0] d1 = 4'h0;
  logic [3:0] d2 = 4'h0;
  logic [3:0] d3 = 4'h0;
  logic [3:0] lvl;
  always_ff @(posedge sys_clk) begin
    d1 <= lineReq;
    d2 <= d1;
    d3 <= d2;
  end
  assign lvl = slow ? d3 : d1;
  assign {carrier_detect_pin_n, ring_pin_n, set_ready_pin_n, clear_to_send_pin_n} = ~lvl;
endmodule
`default_nettype wire

//--- ims_pkg.sv
package ims_pkg;
  // ****************************************
  // Register map
  // ****************************************
  // Printed offsets are not word aligned, so the low byte is the index
  localparam logic [31:0] IMS_OFS_LSTAT = 32'hd8700085;
  localparam logic [31:0] IMS_OFS_MSR = 32'hd8700086;
  localparam logic [31:0] IMS_OFS_SCR = 32'hd8700087;
  localparam logic [31:0] IMS_OFS_CTRL = 32'hd8700089;
  localparam int IMS_AW = 10;
  localparam logic [7:0] IMS_IDX_LSTAT = IMS_OFS_LSTAT[7:0];
  localparam logic [7:0] IMS_IDX_MSR = IMS_OFS_MSR[7:0];
  localparam logic [7:0] IMS_IDX_SCR = IMS_OFS_SCR[7:0];
  localparam logic [7:0] IMS_IDX_CTRL = IMS_OFS_CTRL[7:0];
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int IMS_LS_PLE = 3;
  localparam int IMS_LS_CRE = 2;
  localparam int IMS_EX_PLOAD = 7;
  localparam int IMS_EX_UNDR = 6;
  localparam int IMS_EX_BUSY = 5;
  localparam int IMS_EX_ABND = 4;
  localparam int IMS_EX_FSTOP = 3;
  localparam int IMS_EX_FINAL = 2;
  localparam int IMS_EX_EOF = 1;
  localparam int IMS_EX_TOUT = 0;
  localparam int IMS_CT_EXT = 0;
  localparam int IMS_CT_FIR = 1;
  localparam int IMS_CT_FES = 2;
  localparam int IMS_CT_PIPE = 3;
  localparam logic [7:0] IMS_SCR_RST = 8'hff;
  localparam logic [7:0] IMS_EXT_RST = 8'h00;
  localparam logic [3:0] IMS_CTRL_RST = 4'h0;
  localparam logic [3:0] IMS_PIN_RST = 4'hf;
  localparam logic [1:0] IMS_RESP_OK = 2'h0;
  localparam logic [1:0] IMS_RESP_ERR = 2'h2;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic finalAtBottom;
    logic crcBad;
    logic ppmIllegal;
    logic startFlag;
    logic stopFlag;
    logic finalPush;
    logic finalPop;
    logic fifoRead;
    logic timeout;
    logic abandon;
    logic frameStatus6;
    logic busy;
  } ims_rx_evt_s;
  typedef struct packed {
    logic empty;
    logic underrun;
    logic lenReached;
    logic fifoWrite;
  } ims_tx_evt_s;
endpackage

//--- ims_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Fast mode: PHY error at final data
// - Bad PPM or repeated start is error
// - MSR bits 7:4 show pin levels
// - Bit 3: carrier changed since read
// - Bit 2: ring rose since read
// - Bit 1: set-ready changed since read
// - Bit 0: clear-to-send changed since read
// - Reset: flags zero, levels follow pins
// - Scratch byte, resets all ones
// - Extended register shares scratch address
// - Pipeline load flag, read clears
// - Write one clears ident rev bit
// - Load when enabled and tx empty
// - Underrun flag, write one clears
// - Bit 5 follows frame reception
// - Abandon sets bit 4, soft reset clears
// - Frame-end stop halts, sets bit 3
// - Final marker cleared by tx write
// - EOF while final byte in FIFO
// - Timeout flag, FIFO read clears
module ims_status_regs
  import ims_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic softReset,
  // AXI4-Lite write
  input wire logic [IMS_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [IMS_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Modem pins
  input wire logic carrier_detect_pin_n,
  input wire logic ring_pin_n,
  input wire logic set_ready_pin_n,
  input wire logic clear_to_send_pin_n,
  // Datapath events
  input wire ims_rx_evt_s rxEvt,
  input wire ims_tx_evt_s txEvt,
  // Datapath controls
  output logic txHalt,
  output logic finalDataMark,
  output logic pipelineLoad,
  output logic identRevClear,
  output logic abandonStatus
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic awHeld_r;
  logic wHeld_r;
  logic [7:0] awIdx_r;
  logic [7:0] wByte_r;
  logic wLane_r;
  logic doWrite;
  logic doRead;
  logic [7:0] rdIdx;
  logic [7:0] rdByte;
  logic rdHit;
  logic wrHit;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic bvalid_r;
  logic rvalid_r;

  assign awready = !awHeld_r && !bvalid_r;
  assign wready = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign doRead = arvalid && !rvalid_r;
  assign rdIdx = araddr[IMS_AW-1:2];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_r <= 1'b0;
      awIdx_r <= 8'h00;
    end else if (awvalid && awready) begin
      awHeld_r <= 1'b1;
      awIdx_r <= awaddr[IMS_AW-1:2];
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wHeld_r <= 1'b0;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_r <= 1'b1;
      wByte_r <= wdata[7:0];
      wLane_r <= wstrb[0];
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  always_comb begin
    wrHit = (awIdx_r == IMS_IDX_MSR) || (awIdx_r == IMS_IDX_SCR) ||
      (awIdx_r == IMS_IDX_CTRL) || (awIdx_r == IMS_IDX_LSTAT);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= IMS_RESP_OK;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r <= wrHit ? IMS_RESP_OK : IMS_RESP_ERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Byte lane 0 carries every register; other lanes are ignored
  logic wrEn;
  assign wrEn = doWrite && wLane_r;

  // ****************************************
  // Control register
  // ****************************************
  logic [3:0] ctrl_r;
  logic extMode;
  assign extMode = ctrl_r[IMS_CT_EXT];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= IMS_CTRL_RST;
    end else if (wrEn && awIdx_r == IMS_IDX_CTRL) begin
      ctrl_r <= wByte_r[3:0];
    end
  end

  logic wrExt;
  logic wrScr;
  logic rdExt;
  logic rdMsr;
  logic rdLs;
  assign wrExt = wrEn && awIdx_r == IMS_IDX_SCR && extMode;
  assign wrScr = wrEn && awIdx_r == IMS_IDX_SCR && !extMode;
  assign rdExt = doRead && rdIdx == IMS_IDX_SCR && extMode;
  assign rdMsr = doRead && rdIdx == IMS_IDX_MSR;
  assign rdLs = doRead && rdIdx == IMS_IDX_LSTAT;

  // ****************************************
  // Link status error flags
  // ****************************************
  logic inFrame_r;
  logic encSeen_r;
  logic encNow;
  logic ple_r;
  logic cre_r;
  logic pleSet;
  logic creSet;

  assign encNow = rxEvt.ppmIllegal || (rxEvt.startFlag && inFrame_r);
  assign pleSet = rxEvt.finalAtBottom && ctrl_r[IMS_CT_FIR] && (encSeen_r || encNow);
  assign creSet = rxEvt.finalAtBottom && rxEvt.crcBad;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      inFrame_r <= 1'b0;
    end else if (rxEvt.startFlag) begin
      inFrame_r <= 1'b1;
    end else if (rxEvt.stopFlag) begin
      inFrame_r <= 1'b0;
    end
  end

  // Error memory is per frame, dropped when its final data lands
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      encSeen_r <= 1'b0;
    end else if (rxEvt.finalAtBottom) begin
      encSeen_r <= 1'b0;
    end else if (encNow) begin
      encSeen_r <= 1'b1;
    end
  end

  // Set wins over the clearing read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ple_r <= 1'b0;
      cre_r <= 1'b0;
    end else begin
      ple_r <= pleSet || (ple_r && !rdLs);
      cre_r <= creSet || (cre_r && !rdLs);
    end
  end

  // ****************************************
  // Modem pins
  // ****************************************
  logic [3:0] pinN;
  logic [3:0] sy1_r;
  logic [3:0] sy2_r;
  logic [3:0] sy3_r;
  logic [3:0] pinN_r;
  logic [3:0] level;
  logic [3:0] lastRd_r;
  logic [3:0] delta_r;
  logic [3:0] deltaSet;
  assign pinN = {carrier_detect_pin_n, ring_pin_n, set_ready_pin_n, clear_to_send_pin_n};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= IMS_PIN_RST;
      sy2_r <= IMS_PIN_RST;
      sy3_r <= IMS_PIN_RST;
    end else begin
      sy1_r <= pinN;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  // A bit moves only once two stages agree, filtering glitches
  for (genvar i = 0; i < 4; i++) begin : gPin
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        pinN_r[i] <= IMS_PIN_RST[i];
      end else if (sy2_r[i] == sy3_r[i]) begin
        pinN_r[i] <= sy3_r[i];
      end
    end
  end

  assign level = ~pinN_r;
  assign deltaSet[3] = level[3] != lastRd_r[3];
  assign deltaSet[2] = level[2] && !lastRd_r[2];
  assign deltaSet[1] = level[1] != lastRd_r[1];
  assign deltaSet[0] = level[0] != lastRd_r[0];

  // Reference levels start from the reset pin value (all deasserted), taken one clock after reset
  logic seeded_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seeded_r <= 1'b0;
      lastRd_r <= 4'h0;
    end else if (!seeded_r || rdMsr) begin
      seeded_r <= 1'b1;
      lastRd_r <= level;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      delta_r <= 4'h0;
    end else if (!seeded_r || rdMsr) begin
      delta_r <= 4'h0;
    end else if (wrEn && awIdx_r == IMS_IDX_MSR) begin
      delta_r <= wByte_r[3:0];
    end else begin
      delta_r <= delta_r | deltaSet;
    end
  end

  // ****************************************
  // Scratch byte
  // ****************************************
  logic [7:0] scratch_value_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scratch_value_r <= IMS_SCR_RST;
    end else if (wrScr) begin
      scratch_value_r <= wByte_r;
    end
  end

  // ****************************************
  // Extended status/control
  // ****************************************
  logic loadCond;
  logic loadPrev_r;
  logic pload_r;
  logic undr_r;
  logic abnd_r;
  logic fstop_r;
  logic final_r;
  logic tout_r;
  logic abSt_r;
  logic idClr_r;
  logic [5:0] eofCnt_r;

  // Load waits for tx empty, so enabling early only delays it
  assign loadCond = ctrl_r[IMS_CT_PIPE] && txEvt.empty;
  assign pipelineLoad = loadCond && !loadPrev_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loadPrev_r <= 1'b0;
      pload_r <= 1'b0;
    end else begin
      loadPrev_r <= loadCond;
      pload_r <= pipelineLoad || (pload_r && !rdExt);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idClr_r <= 1'b0;
    end else begin
      idClr_r <= wrExt && wByte_r[IMS_EX_PLOAD];
    end
  end

  logic w1Undr;
  logic w1Stop;
  assign w1Undr = wrExt && wByte_r[IMS_EX_UNDR];
  assign w1Stop = wrExt && wByte_r[IMS_EX_FSTOP];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      undr_r <= 1'b0;
      fstop_r <= 1'b0;
    end else begin
      undr_r <= txEvt.underrun || (undr_r && !w1Undr);
      fstop_r <= (ctrl_r[IMS_CT_FES] && txEvt.lenReached) || (fstop_r && !w1Stop);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      abnd_r <= 1'b0;
      abSt_r <= 1'b0;
    end else if (rxEvt.abandon) begin
      abnd_r <= 1'b1;
      abSt_r <= rxEvt.frameStatus6;
    end else if (softReset) begin
      abnd_r <= 1'b0;
    end
  end

  // Software marking beats a same-cycle FIFO write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      final_r <= 1'b0;
    end else if (wrExt) begin
      final_r <= wByte_r[IMS_EX_FINAL];
    end else if (txEvt.fifoWrite) begin
      final_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      eofCnt_r <= 6'h00;
    end else if (softReset) begin
      eofCnt_r <= 6'h00;
    end else if (rxEvt.finalPush && !rxEvt.finalPop) begin
      eofCnt_r <= eofCnt_r + 6'h01;
    end else if (rxEvt.finalPop && !rxEvt.finalPush && eofCnt_r != 6'h00) begin
      eofCnt_r <= eofCnt_r - 6'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tout_r <= 1'b0;
    end else begin
      tout_r <= rxEvt.timeout || (tout_r && !rxEvt.fifoRead);
    end
  end

  logic [7:0] extVal;
  assign extVal = {pload_r, undr_r, rxEvt.busy, abnd_r, fstop_r, final_r,
    eofCnt_r != 6'h00, tout_r};

  assign txHalt = fstop_r;
  assign finalDataMark = final_r;
  assign identRevClear = idClr_r;
  assign abandonStatus = abSt_r;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    case (rdIdx)
      IMS_IDX_LSTAT: rdByte = {4'h0, ple_r, cre_r, 2'b00};
      IMS_IDX_MSR: rdByte = {level, delta_r | deltaSet};
      IMS_IDX_SCR: rdByte = extMode ? extVal : scratch_value_r;
      IMS_IDX_CTRL: rdByte = {4'h0, ctrl_r};
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= IMS_RESP_OK;
    end else if (doRead) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h0, rdByte};
      rresp_r <= rdHit ? IMS_RESP_OK : IMS_RESP_ERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_ple_final: assert property (@(posedge sys_clk) disable iff (!nrst)
    pleSet |=> ple_r) else $error("phy error flag missed");
  a_cre_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    rdLs && !creSet |=> !cre_r) else $error("crc flag not cleared");
  a_msr_level: assert property (@(posedge sys_clk) disable iff (!nrst)
    rdMsr |=> rdata_r[7:4] == $past(level)) else $error("msr level wrong");
  a_ring_edge: assert property (@(posedge sys_clk) disable iff (!nrst)
    seeded_r && !rdMsr && $rose(level[2]) && lastRd_r[2] == 1'b0 |=> delta_r[2])
    else $error("ring edge missed");
  a_delta_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    seeded_r && rdMsr |=> delta_r == 4'h0) else $error("delta not cleared");
  a_scr_mux: assert property (@(posedge sys_clk) disable iff (!nrst)
    doRead && rdIdx == IMS_IDX_SCR && !extMode |=> rdata_r[7:0] == $past(scratch_value_r))
    else $error("scratch read wrong");
  a_pload_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(loadCond) |=> pload_r) else $error("pipeline load missed");
  a_undr_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    undr_r && !w1Undr |=> undr_r) else $error("underrun lost");
  a_stop_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
    !fstop_r && !ctrl_r[IMS_CT_FES] |=> !fstop_r) else $error("stop outside mode");
  a_tout_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxEvt.fifoRead && !rxEvt.timeout |=> !tout_r) else $error("timeout not cleared");
  a_write_resp: assert property (@(posedge sys_clk) disable iff (!nrst)
    doWrite |=> bvalid_r [*1] ##0 (bvalid_r throughout (!bready) [*1]) or bvalid_r)
    else $error("write response missing");
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ims_pkg::*;
;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam int RX_FAB = 11, RX_PPM = 9, RX_STA = 8, RX_STO = 7, RX_PUSH = 6, RX_POP = 5;
  localparam int RX_RD = 4, RX_TOUT = 3, RX_ABN = 2, TX_UND = 2, TX_LEN = 1, TX_WR = 0;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic softReset = 1'b0;
  logic [IMS_AW-1:0] awaddr = '0;
  logic [IMS_AW-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic cdN, riN, dsN, ctN;
  logic slow = 1'b0;
  logic [3:0] lineReq = 4'h0;
  ims_rx_evt_s rx = '0;
  ims_tx_evt_s tx = '0;
  logic txHalt, finalDataMark, pipelineLoad, identRevClear, abandonStatus;
  int num_errors = 0;
  int total_checks = 0;
  int plCnt = 0;
  int irCnt = 0;
  logic [31:0] seed = 32'hea5d;
  logic [31:0] rdD;
  logic [1:0] rsp;

  always #2.5 sys_clk = ~sys_clk;

  ims_status_regs u_ims_status_regs (.sys_clk(sys_clk), .nrst(nrst), .softReset(softReset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .carrier_detect_pin_n(cdN), .ring_pin_n(riN),
    .set_ready_pin_n(dsN), .clear_to_send_pin_n(ctN), .rxEvt(rx), .txEvt(tx),
    .txHalt(txHalt), .finalDataMark(finalDataMark), .pipelineLoad(pipelineLoad),
    .identRevClear(identRevClear), .abandonStatus(abandonStatus));

  ims_modem_model u_ims_modem_model (.sys_clk(sys_clk), .lineReq(lineReq), .slow(slow),
    .carrier_detect_pin_n(cdN), .ring_pin_n(riN), .set_ready_pin_n(dsN),
    .clear_to_send_pin_n(ctN));

  // Pulse outputs are counted, so no single edge has to be hit
  always @(posedge sys_clk) begin
    if (pipelineLoad === 1'b1) plCnt++;
    if (identRevClear === 1'b1) irCnt++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Flags compare against the levels seen at the previous read
  function automatic logic [7:0] msrExp(input logic [3:0] lv, input logic [3:0] p);
    return {lv, lv[3] ^ p[3], lv[2] & ~p[2], lv[1] ^ p[1], lv[0] ^ p[0]};
  endfunction

  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chkRd(input logic [7:0] e);
    cmp({rsp, rdD}, {IMS_RESP_OK, 24'h0, e});
  endtask

  task automatic chkF(input logic e, input logic g);
    cmp({33'h0, g}, {33'h0, e});
  endtask

  // Trailing edge keeps two accesses from driving one signal in one step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdD = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic prx(input int b);
    rx[b] <= 1'b1;
    @(posedge sys_clk);
    rx[b] <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic ptx(input int b);
    tx[b] <= 1'b1;
    @(posedge sys_clk);
    tx[b] <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic softRst();
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end

  initial begin
    logic [31:0] pick;
    logic [7:0] v;
    logic [3:0] lv;
    logic [3:0] prevLv;
    prevLv = 4'h0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd(IMS_IDX_SCR);
    chkRd(IMS_SCR_RST);
    rd(IMS_IDX_MSR);
    chkRd(8'h00);
    rd(8'h00);
    cmp({rsp, rdD}, {IMS_RESP_ERR, 32'h0});
    wr(8'h00, 8'h55);
    cmp({32'h0, rsp}, {32'h0, IMS_RESP_ERR});
    for (int i = 0; i < 8; i++) begin
      pick = xs();
      v = (i == 0) ? 8'h00 : pick[7:0];
      wr(IMS_IDX_SCR, v);
      rd(IMS_IDX_SCR);
      chkRd(v);
    end
    // Modem lines, all set then all cleared, then random
    for (int i = 0; i < 10; i++) begin
      pick = xs();
      lv = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : pick[3:0];
      lineReq <= lv;
      slow <= pick[8];
      repeat (12) @(posedge sys_clk);
      rd(IMS_IDX_MSR);
      chkRd(msrExp(lv, prevLv));
      prevLv = lv;
    end
    rd(IMS_IDX_MSR);
    chkRd({prevLv, 4'h0});
    wr(IMS_IDX_CTRL, 8'h01);
    rd(IMS_IDX_SCR);
    chkRd(IMS_EXT_RST);
    ptx(TX_UND);
    rd(IMS_IDX_SCR);
    chkRd(8'h40);
    rd(IMS_IDX_SCR);
    chkRd(8'h40);
    wr(IMS_IDX_SCR, 8'h40);
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    rx.busy <= 1'b1;
    @(posedge sys_clk);
    rd(IMS_IDX_SCR);
    chkRd(8'h20);
    rx.busy <= 1'b0;
    @(posedge sys_clk);
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    prx(RX_TOUT);
    rd(IMS_IDX_SCR);
    chkRd(8'h01);
    rd(IMS_IDX_SCR);
    chkRd(8'h01);
    prx(RX_RD);
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    prx(RX_PUSH);
    prx(RX_PUSH);
    prx(RX_POP);
    rd(IMS_IDX_SCR);
    chkRd(8'h02);
    prx(RX_POP);
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    prx(RX_PUSH);
    softRst();
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    rx.frameStatus6 <= 1'b1;
    @(posedge sys_clk);
    prx(RX_ABN);
    chkF(1'b1, abandonStatus);
    rd(IMS_IDX_SCR);
    chkRd(8'h10);
    softRst();
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    wr(IMS_IDX_SCR, 8'h04);
    chkF(1'b1, finalDataMark);
    ptx(TX_WR);
    chkF(1'b0, finalDataMark);
    ptx(TX_LEN);
    chkF(1'b0, txHalt);
    wr(IMS_IDX_CTRL, 8'h05);
    ptx(TX_LEN);
    chkF(1'b1, txHalt);
    rd(IMS_IDX_SCR);
    chkRd(8'h08);
    wr(IMS_IDX_SCR, 8'h08);
    chkF(1'b0, txHalt);
    // Pipeline is enabled only with the transmitter drained
    tx.empty <= 1'b1;
    wr(IMS_IDX_CTRL, 8'h09);
    repeat (2) @(posedge sys_clk);
    cmp(34'(plCnt), 34'h1);
    rd(IMS_IDX_SCR);
    chkRd(8'h80);
    rd(IMS_IDX_SCR);
    chkRd(8'h00);
    wr(IMS_IDX_SCR, 8'h80);
    wr(IMS_IDX_SCR, 8'h00);
    repeat (2) @(posedge sys_clk);
    cmp(34'(irCnt), 34'h1);
    wr(IMS_IDX_CTRL, 8'h00);
    rd(IMS_IDX_SCR);
    chkRd(v);
    // Bad symbol, repeated start, clean, CRC bad, bad symbol in slow mode
    for (int k = 0; k < 5; k++) begin
      wr(IMS_IDX_CTRL, (k == 4) ? 8'h00 : 8'h02);
      rx.crcBad <= (k == 3);
      @(posedge sys_clk);
      prx(RX_STA);
      if (k == 1) prx(RX_STA);
      if (k == 0 || k == 4) prx(RX_PPM);
      prx(RX_STO);
      prx(RX_FAB);
      rd(IMS_IDX_LSTAT);
      chkRd((k == 3) ? 8'h04 : (k < 2) ? 8'h08 : 8'h00);
      rd(IMS_IDX_LSTAT);
      chkRd(8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire
